// File: design/wit_pkg.sv
// Constants, field layouts and carrier types of the watchdog interval timer
package wit_pkg;

    // ************************************************************
    // Bus geometry
    // ************************************************************
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_CTRL_WR = 8'hA8;  // word write: count or control
    localparam logic [7:0] IDX_CTRL_RD = 8'hA8;  // control/status read
    localparam logic [7:0] IDX_CNT_RD  = 8'hA9;  // count read
    localparam logic [7:0] IDX_RSTC_WR = 8'hAA;  // word write: reset control
    localparam logic [7:0] IDX_RSTC_RD = 8'hAB;  // reset control read

    // ************************************************************
    // Password bytes
    // ************************************************************
    localparam logic [7:0] PW_COUNT = 8'h5A;
    localparam logic [7:0] PW_CTRL  = 8'hA5;
    localparam logic [7:0] PW_CLEAR = 8'hA5;
    localparam logic [7:0] PW_OE    = 8'h5A;
    localparam logic [7:0] CLR_DATA = 8'h00;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int unsigned CTRL_OVF_BIT  = 7;
    localparam int unsigned CTRL_MODE_BIT = 6;
    localparam int unsigned CTRL_RUN_BIT  = 5;
    localparam int unsigned CTRL_CKS_LSB  = 0;
    localparam int unsigned RSTC_FLAG_BIT = 7;
    localparam int unsigned RSTC_OE_BIT   = 6;
    localparam logic [1:0] CTRL_RSVD      = 2'h3;
    localparam logic [5:0] RSTC_RSVD      = 6'h3F;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [7:0] CNT_RESET  = 8'h00;
    localparam logic [7:0] CNT_MAX    = 8'hFF;
    localparam logic [2:0] CKS_RESET  = 3'h0;

    // ************************************************************
    // Timing, in system clock states
    // ************************************************************
    localparam int unsigned CHIP_RST_STATES = 518;
    localparam int unsigned PIN_RST_STATES  = 132;
    localparam logic [9:0]  CHIP_RST_CYC    = 10'(CHIP_RST_STATES);
    localparam logic [7:0]  PIN_RST_CYC     = 8'(PIN_RST_STATES);

    // ************************************************************
    // Prescaler
    // ************************************************************
    localparam int unsigned PS_W = 12;

    typedef struct packed {
        logic       mode;   // 1 = watchdog, 0 = interval
        logic       run;
        logic [2:0] cks;
    } wit_ctrl_s;

    // Low prescaler bits that must all be one for a tick
    function automatic logic [PS_W-1:0] wit_ps_mask(input logic [2:0] cks);
        logic [PS_W-1:0] m;
        m = 12'h001;
        unique case (cks)
            3'h0: m = 12'h001;  // /2
            3'h1: m = 12'h01F;  // /32
            3'h2: m = 12'h03F;  // /64
            3'h3: m = 12'h07F;  // /128
            3'h4: m = 12'h0FF;  // /256
            3'h5: m = 12'h1FF;  // /512
            3'h6: m = 12'h7FF;  // /2048
            3'h7: m = 12'hFFF;  // /4096
        endcase
        return m;
    endfunction : wit_ps_mask

endpackage : wit_pkg

// File: design/wit_watchdog.sv
// Watchdog / interval timer with password-protected APB registers
//
// What this block does
// - Watchdog mode needs mode-select and run both set
// - Watchdog overflow holds chip reset 518 states
// - Reset-out pin low 132 states when enabled
// - Output-enable bit gates the reset-out pulse
// - Reset flag tells watchdog from pin reset
// - Simultaneous pin and watchdog reset: pin wins
// - Interval mode overflow requests interrupt, no reset
// - Overflow sets flag with reset or interrupt
// - Reset flag set only on watchdog-mode overflow
// - Internal reset clears overflow, keeps reset flag
// - Interval interrupt follows the overflow flag
// - Counter write beats a coinciding increment
// - Counter counts up, wraps, zero while stopped
// - Clock select picks one of eight dividers
// - Count/control writes need word and password
// - Reset-control writes need word and password
`timescale 1ns/1ps
module wit_watchdog
    import wit_pkg::*;
(
    // Clock, reset, enable
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      clk_en,
    // APB slave
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [wit_pkg::ADDR_W-1:0] paddr,
    input  wire logic [wit_pkg::DATA_W-1:0] pwdata,
    input  wire logic [3:0]                pstrb,
    output logic      [wit_pkg::DATA_W-1:0] prdata,
    output logic                           pready,
    output logic                           pslverr,
    // Reset and interrupt outputs
    output logic                           watchdog_chip_reset,
    output logic                           reset_out_pin_n,
    output logic                           interval_interrupt
);
    import wit_pkg::*;

    // ************************************************************
    // State
    // ************************************************************
    logic [7:0]      timer_count_q;
    wit_ctrl_s       ctrl_q;
    logic            overflow_flag_q;
    logic            ovf_seen_q;
    logic            watchdog_reset_flag_q;
    logic            reset_output_enable_q;
    logic [PS_W-1:0] presc_q;
    logic            chip_rst_q;
    logic [9:0]      chip_cnt_q;
    logic            pin_rst_q;
    logic [7:0]      pin_cnt_q;
    logic [7:0]      rd_data_q;
    logic            rd_valid_q;

    // ************************************************************
    // Bus decode
    // ************************************************************
    logic       access;
    logic       wr_acc;
    logic       rd_acc;
    logic [7:0] idx;
    logic       word_wr;
    logic [7:0] pw;
    logic [7:0] wdata;
    logic       mapped;

    assign pready  = clk_en && rd_valid_q;
    assign access  = psel && penable && pready;
    assign wr_acc  = access && pwrite;
    assign rd_acc  = access && !pwrite;
    assign idx     = (paddr[ADDR_W-1:2] <= 10'(8'hFF)) ? paddr[9:2] : 8'h00;
    assign mapped  = (paddr[ADDR_W-1:10] == 2'h0) && (paddr[1:0] == 2'h0)
                     && (idx >= IDX_CTRL_WR) && (idx <= IDX_RSTC_RD);
    // Both low byte lanes must be written: byte writes are refused
    assign word_wr = wr_acc && mapped && (pstrb[1:0] == 2'h3);
    assign pw      = pwdata[15:8];
    assign wdata   = pwdata[7:0];
    assign pslverr = psel && penable && !mapped;

    logic wr_count;
    logic wr_ctrl;
    logic wr_clear;
    logic wr_oe;

    assign wr_count = word_wr && (idx == IDX_CTRL_WR) && (pw == PW_COUNT);
    assign wr_ctrl  = word_wr && (idx == IDX_CTRL_WR) && (pw == PW_CTRL);
    assign wr_clear = word_wr && (idx == IDX_RSTC_WR) && (pw == PW_CLEAR)
                      && (wdata == CLR_DATA);
    assign wr_oe    = word_wr && (idx == IDX_RSTC_WR) && (pw == PW_OE);

    // ************************************************************
    // Prescaler and tick
    // ************************************************************
    logic tick;

    // Free-running, so a divider change mid-count gives a short first period
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            presc_q <= '0;
        else if (clk_en)
            presc_q <= presc_q + 12'h001;
    end

    assign tick = ((presc_q & wit_ps_mask(ctrl_q.cks)) ==
                   wit_ps_mask(ctrl_q.cks));

    // ************************************************************
    // Overflow event
    // ************************************************************
    logic overflow;
    logic wd_mode;
    logic wd_event;

    assign wd_mode  = ctrl_q.mode && ctrl_q.run;
    assign overflow = ctrl_q.run && tick && !wr_count
                      && (timer_count_q == CNT_MAX) && !chip_rst_q;
    assign wd_event = overflow && wd_mode;

    // ************************************************************
    // Counter
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            timer_count_q <= CNT_RESET;
        else if (clk_en)
        begin
            if (chip_rst_q || !ctrl_q.run)
                timer_count_q <= CNT_RESET;
            else if (wr_count)
                timer_count_q <= wdata;
            else if (tick)
                timer_count_q <= timer_count_q + 8'h01;
        end
    end

    // ************************************************************
    // Control bits
    // ************************************************************
    // Held in reset while the internal watchdog reset is active
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_q.mode <= 1'b0;
            ctrl_q.run  <= 1'b0;
            ctrl_q.cks  <= CKS_RESET;
        end
        else if (clk_en)
        begin
            if (chip_rst_q)
            begin
                ctrl_q.mode <= 1'b0;
                ctrl_q.run  <= 1'b0;
                ctrl_q.cks  <= CKS_RESET;
            end
            else if (wr_ctrl)
            begin
                ctrl_q.mode <= wdata[CTRL_MODE_BIT];
                ctrl_q.run  <= wdata[CTRL_RUN_BIT];
                ctrl_q.cks  <= wdata[CTRL_CKS_LSB +: 3];
            end
        end
    end

    // ************************************************************
    // Overflow flag
    // ************************************************************
    // Clearing needs a read that saw the flag set, then a zero write
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ovf_seen_q <= 1'b0;
        else if (clk_en)
        begin
            if (chip_rst_q || !overflow_flag_q)
                ovf_seen_q <= 1'b0;
            else if (rd_acc && (idx == IDX_CTRL_RD) && rd_data_q[CTRL_OVF_BIT])
                ovf_seen_q <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            overflow_flag_q <= 1'b0;
        else if (clk_en)
        begin
            if (chip_rst_q)
                overflow_flag_q <= 1'b0;
            else if (overflow)
                overflow_flag_q <= 1'b1;
            else if (wr_ctrl && ovf_seen_q && !wdata[CTRL_OVF_BIT])
                overflow_flag_q <= 1'b0;
        end
    end

    // ************************************************************
    // Reset control register
    // ************************************************************
    // Of the resets only the reset pin clears these; a watchdog reset leaves them
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            watchdog_reset_flag_q <= 1'b0;
        else if (clk_en)
        begin
            if (wd_event)
                watchdog_reset_flag_q <= 1'b1;
            else if (wr_clear)
                watchdog_reset_flag_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            reset_output_enable_q <= 1'b0;
        else if (clk_en && wr_oe)
            reset_output_enable_q <= wdata[RSTC_OE_BIT];
    end

    // ************************************************************
    // Internal chip reset pulse
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            chip_rst_q <= 1'b0;
            chip_cnt_q <= '0;
        end
        else if (clk_en)
        begin
            if (wd_event)
            begin
                chip_rst_q <= 1'b1;
                chip_cnt_q <= CHIP_RST_CYC - 10'h001;
            end
            else if (chip_rst_q)
            begin
                if (chip_cnt_q == 10'h000)
                    chip_rst_q <= 1'b0;
                else
                    chip_cnt_q <= chip_cnt_q - 10'h001;
            end
        end
    end

    // ************************************************************
    // External reset pin pulse
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_rst_q <= 1'b0;
            pin_cnt_q <= '0;
        end
        else if (clk_en)
        begin
            if (wd_event && reset_output_enable_q)
            begin
                pin_rst_q <= 1'b1;
                pin_cnt_q <= PIN_RST_CYC - 8'h01;
            end
            else if (pin_rst_q)
            begin
                if (pin_cnt_q == 8'h00)
                    pin_rst_q <= 1'b0;
                else
                    pin_cnt_q <= pin_cnt_q - 8'h01;
            end
        end
    end

    assign watchdog_chip_reset = chip_rst_q;
    assign reset_out_pin_n     = !pin_rst_q;

    // ************************************************************
    // Interval interrupt
    // ************************************************************
    // Level request; drops when software clears the overflow flag
    assign interval_interrupt = overflow_flag_q && !ctrl_q.mode;

    // ************************************************************
    // Read data
    // ************************************************************
    logic [7:0] rd_byte;

    always_comb
    begin
        rd_byte = 8'h00;
        if (!pwrite && mapped)
        begin
            unique case (idx)
                IDX_CTRL_RD:
                    rd_byte = {overflow_flag_q, ctrl_q.mode, ctrl_q.run,
                               CTRL_RSVD, ctrl_q.cks};
                IDX_CNT_RD:
                    rd_byte = timer_count_q;
                IDX_RSTC_RD:
                    rd_byte = {watchdog_reset_flag_q, reset_output_enable_q,
                               RSTC_RSVD};
                default:
                    rd_byte = 8'h00;
            endcase
        end
    end

    // Captured in the setup cycle so read data leaves a flop;
    // a frozen setup edge costs one wait state, never stale data
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rd_data_q  <= 8'h00;
            rd_valid_q <= 1'b0;
        end
        else if (clk_en)
        begin
            if (access)
            begin
                rd_data_q  <= 8'h00;
                rd_valid_q <= 1'b0;
            end
            else if (psel && !rd_valid_q)
            begin
                rd_data_q  <= rd_byte;
                rd_valid_q <= 1'b1;
            end
        end
    end

    assign prdata = {24'h000000, rd_data_q};

endmodule : wit_watchdog

// File: test/tb_top.sv
// Self-checking testbench for the watchdog interval timer
`timescale 1ns/1ps
module tb_top;
    import wit_pkg::*;
    logic              pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, chip, pin_n, irq;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata;
    logic [3:0]        pstrb;
    int                fail_count, comparisons;
    int                cyc = 0;
    int                dv [8] = '{2, 32, 64, 128, 256, 512, 2048, 4096};

    wit_watchdog i_wit_watchdog (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .watchdog_chip_reset(chip),
        .reset_out_pin_n(pin_n), .interval_interrupt(irq));

    initial
    begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    always @(posedge pclk) cyc <= cyc + 1;

    task automatic close_out();
        if (fail_count == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : close_out

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic do_reset();
        presetn <= 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
    endtask : do_reset

    // Request held until pready is seen
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                       input logic [3:0] s, output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        pstrb  <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] i, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, {2'h0, i, 2'h0}, d, 4'hF, r, e);
    endtask : wr

    task automatic rd(input logic [7:0] i, input logic [31:0] exp, input string what);
        logic [31:0] r;
        logic        e;
        apb(1'b0, {2'h0, i, 2'h0}, 32'h0, 4'h0, r, e);
        chk(what, r, exp);
    endtask : rd

    task automatic t_regs();
        logic [31:0] r;
        logic        e;
        rd(IDX_CTRL_RD, 32'h18, "ctrl");
        rd(IDX_CNT_RD, 32'h00, "count");
        rd(IDX_RSTC_RD, 32'h3F, "rstc");
        apb(1'b1, {2'h0, IDX_CTRL_WR, 2'h0}, 32'hA577, 4'h1, r, e);
        wr(IDX_CTRL_WR, 32'h3C77);
        rd(IDX_CTRL_RD, 32'h18, "refused");
        apb(1'b0, 12'h2C0, 32'h0, 4'h0, r, e);
        chk("unmapped", {r[30:0], e}, 32'h1);
        apb(1'b0, 12'h2A1, 32'h0, 4'h0, r, e);
        chk("misaligned", {r[30:0], e}, 32'h1);
    endtask : t_regs

    task automatic t_interval();
        int n;
        wr(IDX_CTRL_WR, 32'hA520);
        wr(IDX_CTRL_WR, 32'h5AFF);
        for (n = 0; irq !== 1'b1 && n < 20; n++) @(posedge pclk);
        chk("irq", {chip, irq}, 32'h1);
        rd(IDX_CTRL_RD, 32'hB8, "ovf");
        wr(IDX_CTRL_WR, 32'hA520);
        @(posedge pclk);
        chk("irq clr", irq, 32'h0);
        wr(IDX_CTRL_WR, 32'hA500);
        rd(IDX_CNT_RD, 32'h00, "stopped");
    endtask : t_interval

    // Period between overflows equals the divider
    task automatic t_div();
        int n;
        int t0;
        logic [31:0] c;
        for (int k = 1; k < 8; k++)
        begin
            c = 32'(k);
            wr(IDX_CTRL_WR, 32'hA500 | c);
            wr(IDX_CTRL_WR, 32'hA520 | c);
            wr(IDX_CTRL_WR, 32'h5AFF);
            for (n = 0; irq !== 1'b1 && n < 9000; n++) @(posedge pclk);
            t0 = cyc;
            rd(IDX_CTRL_RD, 32'hB8 | c, "ovf");
            wr(IDX_CTRL_WR, 32'h5AFF);
            wr(IDX_CTRL_WR, 32'hA520 | c);
            // Let the flag clear settle before looking for the next overflow
            @(posedge pclk);
            for (n = 0; irq !== 1'b1 && n < 9000; n++) @(posedge pclk);
            chk("period", 32'(cyc - t0), 32'(dv[k]));
            rd(IDX_CTRL_RD, 32'hB8 | c, "ovf");
            wr(IDX_CTRL_WR, 32'hA500 | c);
        end
    endtask : t_div

    task automatic t_wd(input logic oe);
        int n;
        int np;
        int ne;
        logic q;
        wr(IDX_RSTC_WR, {16'h0, 8'h5A, 1'b0, oe, 6'h00});
        wr(IDX_CTRL_WR, 32'hA540);
        wr(IDX_CTRL_WR, 32'hA560);
        wr(IDX_CTRL_WR, 32'h5AFF);
        for (n = 0; chip !== 1'b1 && n < 20; n++) @(posedge pclk);
        np = 0;
        ne = 0;
        q = 1'b0;
        for (n = 0; chip === 1'b1 && n < 600; n++)
        begin
            np += int'(pin_n === 1'b0 && clk_en === 1'b1);
            ne += int'(clk_en === 1'b1);
            q = q | irq;
            // Freeze part of the pulse; lengths count enabled cycles only
            clk_en <= !(oe && n >= 100 && n < 120);
            @(posedge pclk);
        end
        chk("chip len", 32'(ne), 32'd518);
        chk("pin len", 32'(np), oe ? 32'd132 : 32'd0);
        chk("irq", q, 32'h0);
        rd(IDX_RSTC_RD, {24'h0, 1'b1, oe, 6'h3F}, "flag");
        rd(IDX_CTRL_RD, 32'h18, "ctrl");
        wr(IDX_RSTC_WR, 32'hA501);
        rd(IDX_RSTC_RD, {24'h0, 1'b1, oe, 6'h3F}, "kept");
        wr(IDX_RSTC_WR, 32'hA500);
        rd(IDX_RSTC_RD, {24'h0, 1'b0, oe, 6'h3F}, "clr");
    endtask : t_wd

    // Kicked watchdog stays quiet; a pin reset then cuts the pulse
    task automatic t_pin();
        int n;
        wr(IDX_RSTC_WR, 32'h5A40);
        wr(IDX_CTRL_WR, 32'hA540);
        wr(IDX_CTRL_WR, 32'hA560);
        for (n = 0; n < 6; n++)
        begin
            repeat (100) @(posedge pclk);
            wr(IDX_CTRL_WR, 32'h5A00);
            chk("kicked", chip, 32'h0);
        end
        for (n = 0; chip !== 1'b1 && n < 700; n++) @(posedge pclk);
        repeat (5) @(posedge pclk);
        chk("pulse", {chip, pin_n}, 32'h2);
        do_reset();
        @(posedge pclk);
        chk("pin reset", {chip, pin_n, irq}, 32'h2);
        rd(IDX_RSTC_RD, 32'h3F, "pin clears");
        rd(IDX_CTRL_RD, 32'h18, "ctrl");
    endtask : t_pin

    initial
    begin
        repeat (60000) @(posedge pclk);
        fail_count++;
        close_out();
    end

    initial
    begin
        {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        clk_en = 1'b1;
        fail_count = 0;
        comparisons = 0;
        do_reset();
        t_regs();
        t_interval();
        t_div();
        t_wd(1'b1);
        t_wd(1'b0);
        t_pin();
        close_out();
    end
endmodule : tb_top

// File: test/wit_watchdog_asserts.sv
// Port checker for the watchdog interval timer
`timescale 1ns/1ps
module wit_watchdog_asserts
    import wit_pkg::*;
(
    // Clock and reset
    input wire logic                       pclk,
    input wire logic                       presetn,
    input wire logic                       clk_en,
    // APB
    input wire logic                       psel,
    input wire logic                       penable,
    input wire logic                       pwrite,
    input wire logic [wit_pkg::ADDR_W-1:0] paddr,
    input wire logic [wit_pkg::DATA_W-1:0] prdata,
    input wire logic                       pslverr,
    // Outputs
    input wire logic                       watchdog_chip_reset,
    input wire logic                       reset_out_pin_n,
    input wire logic                       interval_interrupt
);
    logic [9:0] chip_q;
    logic [7:0] pin_q;

    // Pulse lengths, frozen with the enable
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            chip_q <= 10'h000;
        else
            chip_q <= watchdog_chip_reset ? chip_q + 10'(clk_en) : 10'h000;
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            pin_q <= 8'h00;
        else
            pin_q <= reset_out_pin_n ? 8'h00 : pin_q + 8'(clk_en);

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_chip_start; $rose(watchdog_chip_reset); endsequence
    sequence s_pin_start; $fell(reset_out_pin_n); endsequence

    property p_chip_len; $fell(watchdog_chip_reset) |-> chip_q == CHIP_RST_CYC; endproperty
    a_chip_len: assert property (p_chip_len) else $error("chip reset length");
    property p_chip_max; chip_q <= CHIP_RST_CYC; endproperty
    a_chip_max: assert property (p_chip_max) else $error("chip reset too long");
    property p_pin_len; $rose(reset_out_pin_n) |-> pin_q == PIN_RST_CYC; endproperty
    a_pin_len: assert property (p_pin_len) else $error("reset out length");
    property p_pin_start; s_pin_start |-> s_chip_start; endproperty
    a_pin_start: assert property (p_pin_start) else $error("reset out start");
    property p_pin_inside; !reset_out_pin_n |-> watchdog_chip_reset; endproperty
    a_pin_inside: assert property (p_pin_inside) else $error("reset out alone");
    property p_irq_quiet; watchdog_chip_reset |-> !interval_interrupt; endproperty
    a_irq_quiet: assert property (p_irq_quiet) else $error("irq in reset");
    property p_irq_hold; interval_interrupt && !(psel && penable && pwrite) |=> interval_interrupt; endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("irq dropped");
    property p_bad_addr; psel && penable && paddr[1:0] != 2'h0 |-> pslverr && prdata == '0; endproperty
    a_bad_addr: assert property (p_bad_addr) else $error("unmapped access");
endmodule : wit_watchdog_asserts

bind wit_watchdog wit_watchdog_asserts i_wit_watchdog_asserts (.pclk(pclk), .presetn(presetn),
    .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .pslverr(pslverr), .watchdog_chip_reset(watchdog_chip_reset), .reset_out_pin_n(reset_out_pin_n),
    .interval_interrupt(interval_interrupt));
